/* led_fault_map.svh */
// Offsets, field positions, reset values and timing counts of the LED fault block.
`ifndef LED_FAULT_MAP_SVH
`define LED_FAULT_MAP_SVH

// Number of LED string sinks.
`define NUM_STRINGS 7
// Clock period of i_clock in nanoseconds.
`define CLK_PERIOD_NS 5
// Least time the input must stay above the threshold before restart.
`define UV_RELEASE_NS 1000
// The same time in clock cycles, rounded up.
`define UV_RELEASE_CYCLES ((`UV_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Status bit positions.
`define ST_OPEN 0
`define ST_SHORT 1
`define ST_UV 2
`define ST_OC 3
`define ST_THERM 4
`define ST_WIDTH 5
// Boost voltage code in 0.25 V steps above 10 V; 38 V is the maximum.
`define VOLT_W 7
`define VOLT_MAX 7'h70
// Hop difference thresholds in 0.25 V steps: 3, 5, 7 and 9 volts.
`define HOP_THR_3V 7'h0c
`define HOP_THR_5V 7'h14
`define HOP_THR_7V 7'h1c
`define HOP_THR_9V 7'h24
// Low threshold base (0.5 V) and the Mid offset (0.5 V), both in 0.25 V steps.
`define LOW_BASE_QV 4'h2
`define MID_OFFSET_QV 4'h2

`endif

/* led_fault_pkg.sv */
// Types shared by the LED fault detection and reporting block.
`default_nettype none
package led_fault_pkg;
  // Detection method selection.
  typedef enum logic [1:0] {
    DETECT_OFF  = 2'b00,
    DETECT_CMP  = 2'b01,
    DETECT_HOP  = 2'b10,
    DETECT_BOTH = 2'b11
  } detect_mode_t;
  // Under-voltage supervisor states.
  typedef enum logic [1:0] {
    UV_RUN     = 2'b00,
    UV_TRIP    = 2'b01,
    UV_RECOVER = 2'b10
  } uv_state_t;
endpackage
`default_nettype wire

/* string_volt_mem.sv */
// Small memory holding the last boost voltage used for each LED string.
`include "led_fault_map.svh"
`default_nettype none
module string_volt_mem (
  input wire logic i_clock,
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_addr,
  input wire logic [`VOLT_W-1:0] i_wr_data,
  input wire logic [2:0] i_rd_addr,
  output logic [`VOLT_W-1:0] o_rd_data
);
  // One word per string.
  logic [`VOLT_W-1:0] mem [0:`NUM_STRINGS-1];

  // Write port and registered read port; a read of the written word sees the old value.
  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule
`default_nettype wire

/* led_fault_detect_report.sv */
// LED string fault detection, supply and thermal supervision, and fault reporting.
// Operation
// - Two-bit setting selects comparator and hopping detection.
// - Comparator mode watches every driver voltage continuously.
// - Near-zero pin, others above High: open.
// - Comparator verdicts need several simultaneously active strings.
// - Driver pin above High threshold: short.
// - Hopping only in phase-shifted, low duty dimming.
// - Maximum voltage with large consecutive difference: open.
// - All strings near maximum gives no open.
// - Voltage drop beyond threshold versus neighbour: short.
// - Hopping short only with single active string.
// - Difference threshold codes give 3/5/7/9 volts.
// - Fault pulls fault pin low, sets status.
// - Status read clears status and fault pin.
// - Pin once per LED type until enable pulse.
// - Faulty string excluded from boost adjustment.
// - Under-voltage select: 0 gives 6V, 1 gives 3V.
// - Under-voltage always watched; shutdown, pin, status.
// - Restart above threshold, with hysteresis against retriggering.
// - Boost over-current shuts down and sets flag.
// - Thermal shutdown at 150C, resume below 130C.
// - Mid threshold sits 0.5V above Low.
// - Backlight control rising again clears status, pin.
`include "led_fault_map.svh"
`default_nettype none
module led_fault_detect_report
  import led_fault_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_fault_mode_select,
  input wire logic [1:0] i_hop_difference_threshold,
  input wire logic i_undervoltage_level_select,
  input wire logic [2:0] i_low_threshold_code,
  input wire logic i_backlight_on_control,
  input wire logic i_status_read,
  input wire logic i_phase_shifted_dimming,
  input wire logic i_low_duty,
  input wire logic [`NUM_STRINGS-1:0] i_string_active,
  input wire logic [`NUM_STRINGS-1:0] i_below_low,
  input wire logic [`NUM_STRINGS-1:0] i_above_high,
  input wire logic i_vin_below_6v,
  input wire logic i_vin_below_3v,
  input wire logic i_boost_overcurrent,
  input wire logic i_temp_above_150c,
  input wire logic i_temp_below_130c,
  input wire logic i_enable_pin,
  input wire logic i_step_valid,
  input wire logic [2:0] i_step_string,
  input wire logic [`VOLT_W-1:0] i_step_volt,
  input wire logic i_fault_pin_in,
  output logic o_fault_pin_out,
  output logic o_fault_pin_oe,
  output logic [`ST_WIDTH-1:0] o_status,
  output logic [`NUM_STRINGS-1:0] o_excluded_strings,
  output logic o_shutdown,
  output logic [3:0] o_low_thr_qv,
  output logic [3:0] o_mid_thr_qv
);
  localparam int NS = `NUM_STRINGS;
  localparam int XW = 2 * NS + 6;

  // All inputs that come from analog comparators or the enable pin.
  logic [XW-1:0] ext;
  // Filtered copies of those inputs.
  logic [XW-1:0] flt;
  assign ext = {i_enable_pin, i_temp_below_130c, i_temp_above_150c, i_boost_overcurrent,
                i_vin_below_3v, i_vin_below_6v, i_above_high, i_below_low};

  // Three stages and a filtered flop per input, reset to the idle level (enable and cool-down idle high) so no
  // false edge follows reset; the filtered level moves only when stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < XW; g++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          s1_reg <= (g >= XW - 2);
          s2_reg <= (g >= XW - 2);
          s3_reg <= (g >= XW - 2);
          flt[g] <= (g >= XW - 2);
        end else begin
          s1_reg <= ext[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            flt[g] <= s3_reg;
          end
        end
      end
    end
  endgenerate

  // Filtered views of the comparator, supply, thermal and enable inputs.
  wire [NS-1:0] low_f = flt[NS-1:0];
  wire [NS-1:0] high_f = flt[2*NS-1:NS];
  wire vin6_f = flt[2*NS];
  wire vin3_f = flt[2*NS+1];
  wire oc_f = flt[2*NS+2];
  wire hot_f = flt[2*NS+3];
  wire cool_f = flt[2*NS+4];
  wire en_f = flt[2*NS+5];

  // Registered state, plus the combinational next state uv_next.
  logic [`ST_WIDTH-1:0] status_reg;
  logic pin_reg;
  logic [NS-1:0] excl_reg;
  logic open_armed_reg;
  logic short_armed_reg;
  logic en_prev_reg;
  logic bl_prev_reg;
  logic oc_reg;
  logic therm_reg;
  uv_state_t uv_reg;
  uv_state_t uv_next;
  logic [15:0] uv_cnt_reg;
  logic [NS-1:0] seen_reg;
  logic st_valid_reg;
  logic [2:0] st_string_reg;
  logic [`VOLT_W-1:0] st_volt_reg;
  logic st_single_reg;
  logic [`VOLT_W-1:0] prev_volt;

  // Mode decode.
  detect_mode_t mode;
  assign mode = detect_mode_t'(i_fault_mode_select);
  wire cmp_on = (mode == DETECT_CMP) || (mode == DETECT_BOTH);
  wire hop_on = (mode == DETECT_HOP) || (mode == DETECT_BOTH);

  // Strings still judged; excluded strings drop out of all decisions except the starved-string test of the comparator short check.
  wire [NS-1:0] act = i_string_active & ~excl_reg;
  wire multi_active = |(act & (act - NS'(1)));
  wire single_active = (act != '0) && !multi_active;

  // Comparator verdicts per string.
  logic [NS-1:0] cmp_open;
  logic [NS-1:0] cmp_short;
  generate
    for (g = 0; g < NS; g++) begin : g_cmp
      wire [NS-1:0] others = act & ~(NS'(1) << g);
      // Pin near zero while every other active string is above High.
      assign cmp_open[g] = cmp_on && multi_active && act[g] && low_f[g]
                           && ((others & ~high_f) == '0);
      // Pin above High while no active string, excluded or not, is starved.
      assign cmp_short[g] = cmp_on && multi_active && act[g] && high_f[g]
                            && ((i_string_active & low_f) == '0);
    end
  endgenerate

  // Hopping: the neighbour in phase order is the previous string.
  wire hop_ok = hop_on && i_phase_shifted_dimming && i_low_duty;
  wire [2:0] prev_addr = (i_step_string == 3'h0) ? 3'(NS - 1) : i_step_string - 3'h1;
  logic [2:0] st_prev_reg;
  logic [`VOLT_W-1:0] hop_thr;
  assign hop_thr = (i_hop_difference_threshold == 2'b00) ? `HOP_THR_3V :
                   (i_hop_difference_threshold == 2'b01) ? `HOP_THR_5V :
                   (i_hop_difference_threshold == 2'b10) ? `HOP_THR_7V :
                   `HOP_THR_9V;
  wire st_judge = st_valid_reg && seen_reg[st_prev_reg] && !excl_reg[st_string_reg];
  wire up = st_volt_reg > prev_volt;
  wire [`VOLT_W-1:0] rise = st_volt_reg - prev_volt;
  wire [`VOLT_W-1:0] fall = prev_volt - st_volt_reg;
  // At maximum with a large rise over the neighbour; all near 38 V gives no rise.
  wire hop_open = st_judge && (st_volt_reg == `VOLT_MAX) && up
                  && (rise > hop_thr);
  wire hop_short = st_judge && st_single_reg && !up
                   && (fall > hop_thr);
  wire [NS-1:0] hop_str = NS'(1) << st_string_reg;
  wire [NS-1:0] new_open = cmp_open | (hop_open ? hop_str : '0);
  wire [NS-1:0] new_short = cmp_short | (hop_short ? hop_str : '0);

  // Previous boost voltage of each string.
  string_volt_mem u_mem (
    .i_clock(i_clock),
    .i_wr_en(i_step_valid),
    .i_wr_addr(i_step_string),
    .i_wr_data(i_step_volt),
    .i_rd_addr(prev_addr),
    .o_rd_data(prev_volt)
  );

  // Supervisor inputs and events.
  wire vin_low = i_undervoltage_level_select ? vin3_f : vin6_f;
  wire uv_evt = (uv_reg == UV_RUN) && vin_low;
  wire oc_evt = oc_f && !oc_reg;
  wire therm_evt = hot_f && !therm_reg;
  wire open_evt = |new_open;
  wire short_evt = |new_short;
  wire en_rise = en_f && !en_prev_reg;
  wire bl_rise = i_backlight_on_control && !bl_prev_reg;
  wire clr = i_status_read || bl_rise;

  // Each cause has its own bit; a new event wins over a clear in the same cycle.
  wire [`ST_WIDTH-1:0] evt = {therm_evt, oc_evt, uv_evt, short_evt, open_evt};
  wire [`ST_WIDTH-1:0] status_next = (clr ? '0 : status_reg) | evt;
  // The pin fires once per LED type; supply and thermal events always fire it.
  wire pin_set = (open_evt && open_armed_reg) || (short_evt && short_armed_reg)
                 || uv_evt || oc_evt || therm_evt;
  wire pin_next = (pin_reg && !clr) || pin_set;
  wire uv_done = uv_cnt_reg == 16'(`UV_RELEASE_CYCLES - 1);

  // Under-voltage supervisor: restart only after a steady stretch above threshold.
  always_comb begin
    uv_next = uv_reg;
    unique case (uv_reg)
      UV_RUN: if (vin_low) uv_next = UV_TRIP;
      UV_TRIP: if (!vin_low) uv_next = UV_RECOVER;
      UV_RECOVER: begin
        // A dip during the hold restarts the wait without a new fault.
        if (vin_low) begin
          uv_next = UV_TRIP;
        end else if (uv_done) begin
          uv_next = UV_RUN;
        end
      end
      default: uv_next = UV_TRIP;
    endcase
  end

  // Hysteresis hold counter.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || uv_reg != UV_RECOVER) begin
      uv_cnt_reg <= 16'h0000;
    end else begin
      uv_cnt_reg <= uv_cnt_reg + 16'h0001;
    end
  end

  // Hopping pipeline stage, aligned with the memory read.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st_valid_reg <= 1'b0;
      st_string_reg <= 3'h0;
      st_prev_reg <= 3'h0;
      st_volt_reg <= '0;
      st_single_reg <= 1'b0;
      seen_reg <= '0;
    end else begin
      st_valid_reg <= i_step_valid && hop_ok;
      st_string_reg <= i_step_string;
      st_prev_reg <= prev_addr;
      st_volt_reg <= i_step_volt;
      st_single_reg <= single_active;
      if (i_step_valid) begin
        seen_reg <= seen_reg | (NS'(1) << i_step_string);
      end
    end
  end

  // Fault flags, pin, exclusions and once-per-type arming.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      status_reg <= '0;
      pin_reg <= 1'b0;
      excl_reg <= '0;
      open_armed_reg <= 1'b1;
      short_armed_reg <= 1'b1;
      en_prev_reg <= 1'b1;
      bl_prev_reg <= 1'b1;
      oc_reg <= 1'b0;
      therm_reg <= 1'b0;
      uv_reg <= UV_RUN;
    end else begin
      status_reg <= status_next;
      pin_reg <= pin_next;
      en_prev_reg <= en_f;
      bl_prev_reg <= i_backlight_on_control;
      uv_reg <= uv_next;
      excl_reg <= (en_rise ? '0 : excl_reg) | new_open | new_short;
      open_armed_reg <= en_rise || (open_armed_reg && !open_evt);
      short_armed_reg <= en_rise || (short_armed_reg && !short_evt);
      oc_reg <= oc_f || (oc_reg && !(bl_rise || en_rise));
      therm_reg <= hot_f || (therm_reg && !cool_f);
    end
  end

  // Registered outputs; the pin only ever drives low.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_fault_pin_out <= 1'b0;
      o_fault_pin_oe <= 1'b0;
      o_status <= '0;
      o_excluded_strings <= '0;
      o_shutdown <= 1'b0;
      o_low_thr_qv <= `LOW_BASE_QV;
      o_mid_thr_qv <= `LOW_BASE_QV + `MID_OFFSET_QV;
    end else begin
      o_fault_pin_out <= 1'b0;
      o_fault_pin_oe <= pin_next;
      o_status <= status_next;
      o_excluded_strings <= excl_reg;
      o_shutdown <= (uv_next != UV_RUN) || oc_f || oc_reg || hot_f
                    || (therm_reg && !cool_f);
      o_low_thr_qv <= `LOW_BASE_QV + {1'b0, i_low_threshold_code};
      o_mid_thr_qv <= `LOW_BASE_QV + `MID_OFFSET_QV + {1'b0, i_low_threshold_code};
    end
  end

  // Checks.
  sequence s_uv_low;
    (uv_reg == UV_RUN) && vin_low;
  endsequence
  property p_status_set;
    @(posedge i_clock) disable iff (i_sys_rst) open_evt |=> o_status[`ST_OPEN];
  endproperty
  a_status_set: assert property (p_status_set) else $error("open fault not reported");
  property p_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_status_read && evt == '0 && !pin_set) |=> (o_status == '0 && !o_fault_pin_oe);
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");
  property p_once;
    @(posedge i_clock) disable iff (i_sys_rst)
      (((open_evt && !open_armed_reg && !short_evt) || (short_evt && !short_armed_reg && !open_evt))
       && !uv_evt && !oc_evt && !therm_evt && !pin_reg) |=> !o_fault_pin_oe;
  endproperty
  a_once: assert property (p_once) else $error("pin fired twice for one type");
  property p_single_cmp;
    @(posedge i_clock) disable iff (i_sys_rst) !multi_active |-> (cmp_open | cmp_short) == '0;
  endproperty
  a_single_cmp: assert property (p_single_cmp) else $error("verdict on one string");
  property p_uv;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_uv_low |=> (o_shutdown && o_fault_pin_oe && o_status[`ST_UV]);
  endproperty
  a_uv: assert property (p_uv) else $error("under-voltage not handled");
  property p_uv_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      (uv_reg == UV_RECOVER && uv_cnt_reg == 16'h0000) |=> (uv_reg != UV_RUN);
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("restart without hold");
  property p_mid;
    @(posedge i_clock) disable iff (i_sys_rst)
      ##1 (o_mid_thr_qv == o_low_thr_qv + `MID_OFFSET_QV);
  endproperty
  a_mid: assert property (p_mid) else $error("mid not low plus half volt");
  property p_hop_gate;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_step_valid && !(i_phase_shifted_dimming && i_low_duty)) |=> !st_valid_reg;
  endproperty
  a_hop_gate: assert property (p_hop_gate) else $error("hop judged outside low duty");
  property p_excl;
    @(posedge i_clock) disable iff (i_sys_rst)
      (new_open[0] && !en_rise) |=> ##1 o_excluded_strings[0];
  endproperty
  a_excl: assert property (p_excl) else $error("faulty string not excluded");
endmodule
`default_nettype wire

/* led_far_side_model.sv */
// Far-side model: string pin comparators, supply, temperature and boost step reports.
`include "led_fault_map.svh"
`default_nettype none
module led_far_side_model (
  input wire logic i_clock,
  output logic [`NUM_STRINGS-1:0] o_below_low,
  output logic [`NUM_STRINGS-1:0] o_above_high,
  output logic o_vin_below_6v,
  output logic o_vin_below_3v,
  output logic o_overcurrent,
  output logic o_temp_above_150c,
  output logic o_temp_below_130c,
  output logic o_step_valid,
  output logic [2:0] o_step_string,
  output logic [`VOLT_W-1:0] o_step_volt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Analog conditions that the bench sets: input volts, die temperature, pin states.
  int vin = 12;
  int temp = 25;
  logic oc = 1'b0;
  logic [`NUM_STRINGS-1:0] near_zero = '0;
  logic [`NUM_STRINGS-1:0] high_pin = '0;
  // Comparators follow the analog conditions without delay.
  assign o_below_low = near_zero;
  assign o_above_high = high_pin;
  assign o_vin_below_6v = (vin < 6);
  assign o_vin_below_3v = (vin < 3);
  assign o_overcurrent = oc;
  assign o_temp_above_150c = (temp >= 150);
  assign o_temp_below_130c = (temp < 130);
  // Boost step report, idle at time zero.
  initial begin
    o_step_valid = 1'b0;
    o_step_string = 3'h0;
    o_step_volt = '0;
  end
  // One step report; afterwards the fields are inverted so stale data never looks valid.
  task automatic step(input logic [2:0] s, input logic [`VOLT_W-1:0] v);
    @(negedge i_clock);
    o_step_valid = 1'b1;
    o_step_string = s;
    o_step_volt = v;
    @(negedge i_clock);
    o_step_valid = 1'b0;
    o_step_string = ~s;
    o_step_volt = ~v;
  endtask
endmodule
`default_nettype wire

/* led_fault_detect_report_tb.sv */
// Self-checking testbench of the LED fault detection and reporting block.
`include "led_fault_map.svh"
`default_nettype none
module led_fault_detect_report_tb;
  import led_fault_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs, all defined at time zero.
  logic clk = 1'b0, rst = 1'b1, uv_sel = 1'b0, bl = 1'b1, rd = 1'b0;
  logic dim = 1'b0, lowd = 1'b0, en = 1'b1;
  logic [1:0] mode = 2'h0, hop_thr = 2'h0;
  logic [2:0] lcode = 3'h3;
  logic [6:0] act = 7'h00;
  // Partner outputs and design outputs.
  wire logic [6:0] bl_w, ah_w, svolt, excl;
  wire logic v6, v3, oc, t150, t130, sv, pin_out, oe, shut;
  wire logic [2:0] ss;
  wire logic [4:0] st;
  wire logic [3:0] lthr, mthr;
  // The fault line has a pull-up and is low only while the block drives it.
  wire logic fault_line = oe ? 1'b0 : 1'b1;
  int n_fail = 0;
  int tests_run = 0;
  // Clock of 5 ns period.
  always #2.5 clk = ~clk;
  led_far_side_model pt (.i_clock(clk), .o_below_low(bl_w), .o_above_high(ah_w),
    .o_vin_below_6v(v6), .o_vin_below_3v(v3), .o_overcurrent(oc), .o_temp_above_150c(t150),
    .o_temp_below_130c(t130), .o_step_valid(sv), .o_step_string(ss), .o_step_volt(svolt));
  led_fault_detect_report DUT (.i_clock(clk), .i_sys_rst(rst), .i_fault_mode_select(mode),
    .i_hop_difference_threshold(hop_thr), .i_undervoltage_level_select(uv_sel),
    .i_low_threshold_code(lcode), .i_backlight_on_control(bl), .i_status_read(rd),
    .i_phase_shifted_dimming(dim), .i_low_duty(lowd), .i_string_active(act),
    .i_below_low(bl_w), .i_above_high(ah_w), .i_vin_below_6v(v6), .i_vin_below_3v(v3),
    .i_boost_overcurrent(oc), .i_temp_above_150c(t150), .i_temp_below_130c(t130),
    .i_enable_pin(en), .i_step_valid(sv), .i_step_string(ss), .i_step_volt(svolt),
    .i_fault_pin_in(fault_line), .o_fault_pin_out(pin_out), .o_fault_pin_oe(oe),
    .o_status(st), .o_excluded_strings(excl), .o_shutdown(shut), .o_low_thr_qv(lthr),
    .o_mid_thr_qv(mthr));
  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle status read pulse.
  task automatic read_st();
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
  endtask
  // Read, enable pin low then high, read again: a clean slate.
  task automatic clear_all();
    read_st();
    en = 1'b0;
    tick(8);
    en = 1'b1;
    tick(8);
    read_st();
  endtask
  // Threshold outputs and idle state after reset.
  task automatic t_reset();
    chk("low_thr", lthr, 8'h05);
    chk("mid_thr", mthr, 8'h07);
    chk("status", st, 8'h00);
    chk("pin_out", pin_out, 8'h00);
    chk("line", fault_line, 8'h01);
    // Highest Low code: Low is 0.5 V plus seven quarter volts, Mid half a volt above.
    lcode = 3'h7;
    tick(2);
    chk("low_thr 7", lthr, 8'h09);
    chk("mid_thr 7", mthr, 8'h0b);
    lcode = 3'h3;
    tick(2);
    $display("test reset done");
  endtask
  // Comparator detection: mode gating, short, clear, once-per-type pin, open.
  task automatic t_cmp();
    act = 7'h03;
    pt.high_pin = 7'h02;
    tick(8);
    chk("off", st, 8'h00);
    mode = 2'h1;
    tick(8);
    chk("short", st, 8'h02);
    chk("line", fault_line, 8'h00);
    pt.high_pin = 7'h00;
    tick(8);
    read_st();
    chk("clr st", st, 8'h00);
    chk("clr oe", oe, 8'h00);
    // String 1 is excluded now, so the repeat short comes from string 2.
    act = 7'h07;
    pt.high_pin = 7'h04;
    tick(8);
    chk("again st", st, 8'h02);
    chk("again oe", oe, 8'h00);
    pt.high_pin = 7'h00;
    tick(8);
    clear_all();
    pt.high_pin = 7'h02;
    tick(8);
    chk("rearm oe", oe, 8'h01);
    pt.high_pin = 7'h00;
    tick(8);
    clear_all();
    act = 7'h01;
    pt.high_pin = 7'h01;
    tick(8);
    chk("single", st, 8'h00);
    // Let the pins settle before the open case so no stale High pin looks like a short.
    pt.high_pin = 7'h00;
    tick(8);
    mode = 2'h3;
    act = 7'h07;
    pt.near_zero = 7'h01;
    pt.high_pin = 7'h06;
    tick(8);
    chk("open", st, 8'h01);
    chk("excl", excl, 8'h01);
    pt.near_zero = 7'h00;
    pt.high_pin = 7'h00;
    tick(8);
    clear_all();
    $display("test comparator done");
  endtask
  // Hopping open detection over every threshold code.
  task automatic t_hop_open();
    logic [6:0] t;
    mode = 2'h2;
    dim = 1'b1;
    lowd = 1'b1;
    act = 7'h03;
    for (int i = 0; i < 14; i++) pt.step(3'(i % 7), `VOLT_MAX);
    tick(4);
    chk("all max", st, 8'h00);
    for (int c = 0; c < 4; c++) begin
      hop_thr = 2'(c);
      t = 7'((3 + 2 * c) * 4);
      pt.step(3'h2, `VOLT_MAX - t);
      pt.step(3'h3, `VOLT_MAX);
      tick(4);
      chk("hop equal", st, 8'h00);
      pt.step(3'h2, `VOLT_MAX - t - 7'h01);
      pt.step(3'h3, `VOLT_MAX);
      tick(4);
      chk("hop open", st, 8'h01);
      chk("hop excl", excl, 8'h08);
      clear_all();
    end
    $display("test hop open done");
  endtask
  // Hopping short detection: active count, dimming and duty gating, boundary.
  task automatic t_hop_short();
    hop_thr = 2'h0;
    pt.step(3'h5, 7'h40);
    pt.step(3'h6, 7'h33);
    tick(4);
    chk("two active", st, 8'h00);
    act = 7'h01;
    dim = 1'b0;
    pt.step(3'h6, 7'h33);
    tick(4);
    chk("no dim", st, 8'h00);
    dim = 1'b1;
    lowd = 1'b0;
    pt.step(3'h6, 7'h33);
    tick(4);
    chk("high duty", st, 8'h00);
    lowd = 1'b1;
    pt.step(3'h6, 7'h34);
    tick(4);
    chk("short equal", st, 8'h00);
    pt.step(3'h6, 7'h33);
    tick(4);
    chk("hop short", st, 8'h02);
    chk("hop oe", oe, 8'h01);
    clear_all();
    $display("test hop short done");
  endtask
  // Under-voltage, over-current and thermal supervision.
  task automatic t_supply();
    mode = 2'h0;
    uv_sel = 1'b1;
    pt.vin = 5;
    tick(8);
    chk("uv 3v sel", st, 8'h00);
    uv_sel = 1'b0;
    tick(8);
    chk("uv", st, 8'h04);
    chk("uv shut", shut, 8'h01);
    chk("uv oe", oe, 8'h01);
    read_st();
    tick(2);
    // The first read cleared the latched bit; a lasting cause does not set it again.
    chk("reread", st, 8'h00);
    pt.vin = 12;
    tick(8);
    chk("uv hold", shut, 8'h01);
    tick(250);
    chk("uv run", shut, 8'h00);
    read_st();
    uv_sel = 1'b1;
    pt.vin = 2;
    tick(8);
    chk("uv 3v", st, 8'h04);
    pt.vin = 12;
    tick(250);
    read_st();
    pt.oc = 1'b1;
    tick(8);
    pt.oc = 1'b0;
    tick(8);
    chk("oc", st, 8'h08);
    chk("oc shut", shut, 8'h01);
    bl = 1'b0;
    tick(2);
    bl = 1'b1;
    tick(4);
    chk("bl st", st, 8'h00);
    chk("bl oe", oe, 8'h00);
    pt.temp = 150;
    tick(8);
    chk("hot", st, 8'h10);
    chk("hot shut", shut, 8'h01);
    chk("hot oe", oe, 8'h01);
    pt.temp = 140;
    tick(8);
    chk("warm shut", shut, 8'h01);
    pt.temp = 120;
    tick(8);
    chk("cool shut", shut, 8'h00);
    $display("test supply done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence: reset for 16 cycles, then every scenario.
  initial begin
    tick(16);
    rst = 1'b0;
    tick(6);
    t_reset();
    t_cmp();
    t_hop_open();
    t_hop_short();
    t_supply();
    conclude();
  end
  // Watchdog well beyond the thousand or so cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
